// File: design/mrd_pkg.sv
// Memory reference decoder: shared constants, field positions and operation codes.
// Assumes 16-bit words with bit 0 as the most significant bit of every word.
package mrd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int WORD_W = 16;
  localparam int DISP_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, counted from bit 0 = MSB
  localparam int POS_CLASS = 0;
  localparam int POS_MOVE_OP = 1;
  localparam int POS_AC = 3;
  localparam int POS_EXT_OP = 3;
  localparam int POS_IND = 5;
  localparam int POS_MODE = 6;
  localparam int POS_DISP = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Index mode codes
  localparam logic [1:0] MODE_PAGE0 = 2'h0;
  localparam logic [1:0] MODE_REL = 2'h1;
  localparam logic [1:0] MODE_BASE2 = 2'h2;
  localparam logic [1:0] MODE_BASE3 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Operation codes
  localparam logic [1:0] MOVE_EXT = 2'h0;
  localparam logic [1:0] MOVE_LOAD = 2'h1;
  localparam logic [1:0] MOVE_STORE = 2'h2;
  localparam logic [1:0] EXT_JUMP = 2'h0;
  localparam logic [1:0] EXT_LINK = 2'h1;
  localparam logic [1:0] EXT_ISZ = 2'h2;
  localparam logic [1:0] EXT_DSZ = 2'h3;
  localparam logic [1:0] LINK_ACC = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and arithmetic constants
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;

  typedef enum logic [2:0] {
    MRD_OP_NONE,
    MRD_OP_LOAD_ACC,
    MRD_OP_STORE_ACC,
    MRD_OP_JUMP,
    MRD_OP_JUMP_LINK,
    MRD_OP_INC_SKIP_ZERO,
    MRD_OP_DEC_SKIP_ZERO
  } mrd_op_t;

endpackage

// File: design/mrd_ea_calc.sv
// Memory reference decoder: effective address adder for the four index modes.
// Assumes the displacement and the mode field are already split from the word.
`timescale 1ns/1ps
module mrd_ea_calc (
  // Decoded fields
  input wire logic [1:0] mode,
  input wire logic [7:0] disp,
  // Datapath values
  input wire logic [15:0] pc,
  input wire logic [15:0] base_acc_two,
  input wire logic [15:0] base_acc_three,
  // Result
  output logic [15:0] ea
);

  logic [15:0] disp_sext;
  logic [15:0] base;

  // Bit 8 of the word is disp[7], the sign
  assign disp_sext = {{8{disp[7]}}, disp};

  always_comb begin
    case (mode)
      mrd_pkg::MODE_REL: base = pc;
      mrd_pkg::MODE_BASE2: base = base_acc_two;
      mrd_pkg::MODE_BASE3: base = base_acc_three;
      default: base = mrd_pkg::WORD_RST;
    endcase
  end

  always_comb begin
    if (mode == mrd_pkg::MODE_PAGE0) begin
      ea = {8'h00, disp};
    end else begin
      ea = 16'(base + disp_sext);
    end
  end

endmodule // mrd_ea_calc

// File: design/mrd_decode.sv
// Memory reference decoder: splits the instruction word, forms the effective
// address, follows one indirection and runs the selected operation.
// Assumes a memory port that holds each request until mem_ack and a datapath
// that applies accumulator and counter writes on the cycle they are shown.
`timescale 1ns/1ps
module mrd_decode (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Instruction in
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] instr_pc,
  output logic instr_ready,
  output logic op_done,
  output logic op_reject,
  // Accumulators
  input wire logic [15:0] base_acc_two,
  input wire logic [15:0] base_acc_three,
  output logic [1:0] acc_rd_sel,
  input wire logic [15:0] acc_rd_data,
  output logic acc_wr_en,
  output logic [1:0] acc_wr_sel,
  output logic [15:0] acc_wr_data,
  // Program counter
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic pc_skip,
  // Effective address register
  output logic [15:0] ea,
  output logic ea_valid,
  // Memory
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);

  typedef enum logic [2:0] {ST_IDLE, ST_EA, ST_IND, ST_EXEC, ST_RD, ST_WR} mrd_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Field decoding
  function automatic logic bit_at(input logic [15:0] w, input int pos);
    return w[15 - pos];
  endfunction

  function automatic logic [1:0] fld2(input logic [15:0] w, input int pos);
    return {bit_at(w, pos), bit_at(w, pos + 1)};
  endfunction

  function automatic logic [7:0] disp_of(input logic [15:0] w);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < mrd_pkg::DISP_W; i++) begin
      d[7 - i] = bit_at(w, mrd_pkg::POS_DISP + i);
    end
    return d;
  endfunction

  function automatic mrd_pkg::mrd_op_t op_of(input logic [15:0] w);
    mrd_pkg::mrd_op_t op;
    op = mrd_pkg::MRD_OP_NONE;
    if (!bit_at(w, mrd_pkg::POS_CLASS)) begin
      case (fld2(w, mrd_pkg::POS_MOVE_OP))
        mrd_pkg::MOVE_LOAD: op = mrd_pkg::MRD_OP_LOAD_ACC;
        mrd_pkg::MOVE_STORE: op = mrd_pkg::MRD_OP_STORE_ACC;
        mrd_pkg::MOVE_EXT: begin
          case (fld2(w, mrd_pkg::POS_EXT_OP))
            mrd_pkg::EXT_JUMP: op = mrd_pkg::MRD_OP_JUMP;
            mrd_pkg::EXT_LINK: op = mrd_pkg::MRD_OP_JUMP_LINK;
            mrd_pkg::EXT_ISZ: op = mrd_pkg::MRD_OP_INC_SKIP_ZERO;
            default: op = mrd_pkg::MRD_OP_DEC_SKIP_ZERO;
          endcase
        end
        default: op = mrd_pkg::MRD_OP_NONE;
      endcase
    end
    return op;
  endfunction

  function automatic logic [15:0] neg16(input logic [15:0] v);
    return 16'(~v + mrd_pkg::WORD_ONE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  mrd_state_t st_r, st_nxt;
  mrd_pkg::mrd_op_t op_r, op_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] ea_r, ea_nxt;
  logic ea_valid_r, ea_valid_nxt;
  logic mem_req_r, mem_req_nxt;
  logic mem_we_r, mem_we_nxt;
  logic [15:0] mem_addr_r, mem_addr_nxt;
  logic [15:0] mem_wdata_r, mem_wdata_nxt;
  logic acc_wr_en_r, acc_wr_en_nxt;
  logic [1:0] acc_wr_sel_r, acc_wr_sel_nxt;
  logic [15:0] acc_wr_data_r, acc_wr_data_nxt;
  logic pc_load_r, pc_load_nxt;
  logic [15:0] pc_value_r, pc_value_nxt;
  logic pc_skip_r, pc_skip_nxt;
  logic skip_r, skip_nxt;
  logic done_r, done_nxt;
  logic reject_r, reject_nxt;
  logic [15:0] ea_calc;
  logic [15:0] modified;
  logic [1:0] mode;
  logic [7:0] disp;

  assign mode = fld2(instr_r, mrd_pkg::POS_MODE);
  assign disp = disp_of(instr_r);

  mrd_ea_calc u_ea (
    .mode(mode),
    .disp(disp),
    .pc(pc_r),
    .base_acc_two(base_acc_two),
    .base_acc_three(base_acc_three),
    .ea(ea_calc)
  );

  // Increment, or add the negation of one to decrement
  assign modified = (op_r == mrd_pkg::MRD_OP_INC_SKIP_ZERO) ?
                    16'(mem_rdata + mrd_pkg::WORD_ONE) :
                    16'(mem_rdata + neg16(mrd_pkg::WORD_ONE));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    instr_nxt = instr_r;
    pc_nxt = pc_r;
    ea_nxt = ea_r;
    ea_valid_nxt = ea_valid_r;
    mem_req_nxt = mem_req_r;
    mem_we_nxt = mem_we_r;
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    acc_wr_en_nxt = 1'b0;
    acc_wr_sel_nxt = acc_wr_sel_r;
    acc_wr_data_nxt = acc_wr_data_r;
    pc_load_nxt = 1'b0;
    pc_value_nxt = pc_value_r;
    pc_skip_nxt = 1'b0;
    skip_nxt = skip_r;
    done_nxt = 1'b0;
    reject_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (instr_valid) begin
          if (op_of(instr_word) == mrd_pkg::MRD_OP_NONE) begin
            reject_nxt = 1'b1;
          end else begin
            instr_nxt = instr_word;
            pc_nxt = instr_pc;
            op_nxt = op_of(instr_word);
            ea_valid_nxt = 1'b0;
            st_nxt = ST_EA;
          end
        end
      end
      ST_EA: begin
        ea_nxt = ea_calc;
        if (bit_at(instr_r, mrd_pkg::POS_IND)) begin
          mem_req_nxt = 1'b1;
          mem_we_nxt = 1'b0;
          mem_addr_nxt = ea_calc;
          st_nxt = ST_IND;
        end else begin
          ea_valid_nxt = 1'b1;
          st_nxt = ST_EXEC;
        end
      end
      ST_IND: begin
        if (mem_ack) begin
          ea_nxt = mem_rdata;
          ea_valid_nxt = 1'b1;
          mem_req_nxt = 1'b0;
          st_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        mem_addr_nxt = ea_r;
        st_nxt = ST_RD;
        case (op_r)
          mrd_pkg::MRD_OP_STORE_ACC: begin
            mem_req_nxt = 1'b1;
            mem_we_nxt = 1'b1;
            mem_wdata_nxt = acc_rd_data;
            skip_nxt = 1'b0;
            st_nxt = ST_WR;
          end
          mrd_pkg::MRD_OP_JUMP: begin
            pc_load_nxt = 1'b1;
            pc_value_nxt = ea_r;
            done_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end
          mrd_pkg::MRD_OP_JUMP_LINK: begin
            acc_wr_en_nxt = 1'b1;
            acc_wr_sel_nxt = mrd_pkg::LINK_ACC;
            acc_wr_data_nxt = 16'(pc_r + mrd_pkg::WORD_ONE);
            pc_load_nxt = 1'b1;
            pc_value_nxt = ea_r;
            done_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end
          default: begin
            mem_req_nxt = 1'b1;
            mem_we_nxt = 1'b0;
          end
        endcase
      end
      ST_RD: begin
        if (mem_ack) begin
          if (op_r == mrd_pkg::MRD_OP_LOAD_ACC) begin
            mem_req_nxt = 1'b0;
            acc_wr_en_nxt = 1'b1;
            acc_wr_sel_nxt = fld2(instr_r, mrd_pkg::POS_AC);
            acc_wr_data_nxt = mem_rdata;
            done_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end else begin
            mem_we_nxt = 1'b1;
            mem_wdata_nxt = modified;
            skip_nxt = (modified == mrd_pkg::WORD_RST);
            st_nxt = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (mem_ack) begin
          mem_req_nxt = 1'b0;
          mem_we_nxt = 1'b0;
          pc_skip_nxt = skip_r;
          done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      op_r <= mrd_pkg::MRD_OP_NONE;
      instr_r <= mrd_pkg::WORD_RST;
      pc_r <= mrd_pkg::WORD_RST;
      ea_r <= mrd_pkg::WORD_RST;
      ea_valid_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= mrd_pkg::WORD_RST;
      mem_wdata_r <= mrd_pkg::WORD_RST;
      acc_wr_en_r <= 1'b0;
      acc_wr_sel_r <= 2'h0;
      acc_wr_data_r <= mrd_pkg::WORD_RST;
      pc_load_r <= 1'b0;
      pc_value_r <= mrd_pkg::WORD_RST;
      pc_skip_r <= 1'b0;
      skip_r <= 1'b0;
      done_r <= 1'b0;
      reject_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      instr_r <= instr_nxt;
      pc_r <= pc_nxt;
      ea_r <= ea_nxt;
      ea_valid_r <= ea_valid_nxt;
      mem_req_r <= mem_req_nxt;
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      acc_wr_en_r <= acc_wr_en_nxt;
      acc_wr_sel_r <= acc_wr_sel_nxt;
      acc_wr_data_r <= acc_wr_data_nxt;
      pc_load_r <= pc_load_nxt;
      pc_value_r <= pc_value_nxt;
      pc_skip_r <= pc_skip_nxt;
      skip_r <= skip_nxt;
      done_r <= done_nxt;
      reject_r <= reject_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign instr_ready = (st_r == ST_IDLE) && ce;
  assign acc_rd_sel = fld2(instr_r, mrd_pkg::POS_AC);
  assign op_done = done_r;
  assign op_reject = reject_r;
  assign acc_wr_en = acc_wr_en_r;
  assign acc_wr_sel = acc_wr_sel_r;
  assign acc_wr_data = acc_wr_data_r;
  assign pc_load = pc_load_r;
  assign pc_value = pc_value_r;
  assign pc_skip = pc_skip_r;
  assign ea = ea_r;
  assign ea_valid = ea_valid_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);

  logic [15:0] sext_d;
  assign sext_d = {{8{instr_r[7]}}, instr_r[7:0]};

  sequence s_ea_step(logic [1:0] m);
    st_r == ST_EA && mode == m;
  endsequence

  sequence s_rd_ack(mrd_pkg::mrd_op_t o);
    st_r == ST_RD && mem_ack && op_r == o;
  endsequence

  a_page_zero_ea: assert property (s_ea_step(mrd_pkg::MODE_PAGE0) |=>
    ea_r == {8'h00, $past(instr_r[7:0])}) else $error("page zero address wrong");
  a_relative_ea: assert property (s_ea_step(mrd_pkg::MODE_REL) |=>
    ea_r == 16'($past(pc_r) + $past(sext_d))) else $error("relative address wrong");
  a_base_two_ea: assert property (s_ea_step(mrd_pkg::MODE_BASE2) |=>
    ea_r == 16'($past(base_acc_two) + $past(sext_d))) else $error("base two wrong");
  a_base_three_ea: assert property (s_ea_step(mrd_pkg::MODE_BASE3) |=>
    ea_r == 16'($past(base_acc_three) + $past(sext_d))) else $error("base three wrong");
  a_indirect_fetch: assert property (st_r == ST_IND && mem_ack |=>
    ea_r == $past(mem_rdata) && ea_valid_r) else $error("indirect word not taken");
  a_ea_before_exec: assert property ((pc_load || (mem_req && st_r != ST_IND)) |->
    ea_valid_r && (pc_load ? pc_value == ea_r : mem_addr == ea_r))
    else $error("operation ran before final address");
  a_link_write: assert property (st_r == ST_EXEC && op_r == mrd_pkg::MRD_OP_JUMP_LINK |=>
    acc_wr_en && acc_wr_sel == mrd_pkg::LINK_ACC && acc_wr_data == 16'($past(pc_r) + 16'h0001)
    && pc_load) else $error("link write wrong");
  a_load_dest: assert property (s_rd_ack(mrd_pkg::MRD_OP_LOAD_ACC) |=>
    acc_wr_en && acc_wr_sel == $past(instr_r[12:11]) && acc_wr_data == $past(mem_rdata))
    else $error("load destination wrong");
  a_store_src: assert property (st_r == ST_EXEC && op_r == mrd_pkg::MRD_OP_STORE_ACC |=>
    mem_req && mem_we && mem_wdata == $past(acc_rd_data)) else $error("store wrong");
  a_inc_write: assert property (s_rd_ack(mrd_pkg::MRD_OP_INC_SKIP_ZERO) |=>
    mem_we && mem_wdata == 16'($past(mem_rdata) + 16'h0001)) else $error("inc wrong");
  a_dec_write: assert property (s_rd_ack(mrd_pkg::MRD_OP_DEC_SKIP_ZERO) |=>
    mem_we && mem_wdata == 16'($past(mem_rdata) - 16'h0001)) else $error("dec wrong");
  a_skip_zero: assert property (st_r == ST_WR && mem_ack |=>
    pc_skip == (op_r != mrd_pkg::MRD_OP_STORE_ACC && $past(mem_wdata) == 16'h0000))
    else $error("skip wrong");
  a_reject_other: assert property (st_r == ST_IDLE && instr_valid && instr_word[15] |=>
    op_reject && st_r == ST_IDLE) else $error("non memory word accepted");

endmodule // mrd_decode

// File: tb/mrd_mem_model.sv
// Memory partner for the memory reference decoder: a sparse word memory.
// Assumes each request is held until the acknowledge is sampled.
`timescale 1ns/1ps
module mrd_mem_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [3:0] ack_delay,
  // Answer
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [logic [15:0]];
  logic [3:0] wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Answer after the set wait; read data is only valid with the acknowledge
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      wait_r <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack) begin
      if (wait_r >= ack_delay) begin
        wait_r <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_we) begin
          mem[mem_addr] = mem_wdata;
        end else begin
          mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
        end
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule // mrd_mem_model

// File: tb/tb_top.sv
// Testbench for the memory reference decoder with a memory partner.
// Assumes a 100 MHz clock and inputs driven 1 ns after the rising edge.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [15:0] instr_pc = 16'h0000;
  logic [15:0] accs [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [3:0] ack_delay = 4'h0;
  logic instr_ready, op_done, op_reject, acc_wr_en, pc_load, pc_skip, ea_valid;
  logic mem_req, mem_we, mem_ack;
  logic [1:0] acc_rd_sel, acc_wr_sel, wr_sel;
  logic [15:0] acc_rd_data, acc_wr_data, pc_value, ea, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] wr_data, pcv;
  logic got_wr, got_pcl, got_skip, got_rej, ended;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  assign acc_rd_data = accs[acc_rd_sel];

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  mrd_decode i_mrd_decode (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .instr_ready(instr_ready),
    .op_done(op_done), .op_reject(op_reject), .base_acc_two(accs[2]),
    .base_acc_three(accs[3]), .acc_rd_sel(acc_rd_sel), .acc_rd_data(acc_rd_data),
    .acc_wr_en(acc_wr_en), .acc_wr_sel(acc_wr_sel), .acc_wr_data(acc_wr_data),
    .pc_load(pc_load), .pc_value(pc_value), .pc_skip(pc_skip), .ea(ea),
    .ea_valid(ea_valid), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  mrd_mem_model i_mrd_mem_model (
    .sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .ack_delay(ack_delay),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Offer one word, then collect the output pulses until it completes
  task automatic run(input logic [15:0] word, input logic [15:0] pc);
    int n;
    got_wr = 1'b0;
    got_pcl = 1'b0;
    got_skip = 1'b0;
    got_rej = 1'b0;
    ended = 1'b0;
    instr_word = word;
    instr_pc = pc;
    instr_valid = 1'b1;
    n = 0;
    while (instr_ready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1 instr_valid = 1'b0;
    for (n = 0; n < 80 && !ended; n++) begin
      if (acc_wr_en === 1'b1) begin
        got_wr = 1'b1;
        wr_sel = acc_wr_sel;
        wr_data = acc_wr_data;
      end
      if (pc_load === 1'b1) begin
        got_pcl = 1'b1;
        pcv = pc_value;
      end
      if (pc_skip === 1'b1) got_skip = 1'b1;
      if (op_reject === 1'b1) got_rej = 1'b1;
      ended = (op_done === 1'b1) || (op_reject === 1'b1);
      if (!ended) begin
        @(posedge sys_clk);
        #1;
      end
    end
    check("completion", {15'h0, ended}, 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    logic [7:0] ds [2] = '{8'h85, 8'h7f};
    logic [15:0] sx, exp;
    accs[2] = 16'h1000;
    accs[3] = 16'hfff0;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        sx = {{8{ds[k][7]}}, ds[k]};
        exp = (m == 0) ? {8'h00, ds[k]} : (m == 1) ? 16'h0010 + sx : accs[m] + sx;
        run({5'h00, 1'b0, m[1:0], ds[k]}, 16'h0010);
        check("jump target", pcv, exp);
        check("ea", ea, exp);
        check("ea_valid", {15'h0, ea_valid}, 16'h0001);
      end
    end
  endtask

  task automatic t_link();
    run({5'h01, 1'b0, 2'h1, 8'h04}, 16'hffff);
    check("link write", {15'h0, got_wr}, 16'h0001);
    check("link sel", {14'h0, wr_sel}, 16'h0003);
    check("link data", wr_data, 16'h0000);
    check("link target", pcv, 16'h0003);
  endtask

  task automatic t_move();
    for (int a = 0; a < 4; a++) begin
      ack_delay = a[3:0];
      accs[a] = 16'ha0a0 + a[15:0];
      i_mrd_mem_model.mem[16'h0040 + a[15:0]] = 16'h5500 + a[15:0];
      run({1'b0, 2'b01, a[1:0], 1'b0, 2'h0, 8'h40 + a[7:0]}, 16'h0000);
      check("load sel", {14'h0, wr_sel}, {14'h0, a[1:0]});
      check("load data", wr_data, 16'h5500 + a[15:0]);
      run({1'b0, 2'b10, a[1:0], 1'b0, 2'h0, 8'h80 + a[7:0]}, 16'h0000);
      check("store write", {15'h0, got_wr}, 16'h0000);
      check("stored", i_mrd_mem_model.mem[16'h0080 + a[15:0]], accs[a]);
    end
  endtask

  task automatic t_modify();
    logic [1:0] ext [4] = '{2'h2, 2'h2, 2'h3, 2'h3};
    logic [15:0] init [4] = '{16'hffff, 16'h7fff, 16'h0001, 16'h0000};
    logic [15:0] res [4] = '{16'h0000, 16'h8000, 16'h0000, 16'hffff};
    ack_delay = 4'h1;
    for (int i = 0; i < 4; i++) begin
      i_mrd_mem_model.mem[16'h0060] = init[i];
      run({3'h0, ext[i], 1'b0, 2'h0, 8'h60}, 16'h0100);
      check("modified", i_mrd_mem_model.mem[16'h0060], res[i]);
      check("skip", {15'h0, got_skip}, {15'h0, res[i] == 16'h0000});
      check("no jump", {15'h0, got_pcl}, 16'h0000);
    end
  endtask

  task automatic t_indirect();
    ack_delay = 4'h3;
    i_mrd_mem_model.mem[16'h0020] = 16'h1234;
    i_mrd_mem_model.mem[16'h1234] = 16'hbeef;
    run({1'b0, 2'b01, 2'h1, 1'b1, 2'h0, 8'h20}, 16'h0000);
    check("indirect data", wr_data, 16'hbeef);
    check("indirect ea", ea, 16'h1234);
    run({5'h00, 1'b1, 2'h1, 8'hfe}, 16'h0022);
    check("indirect jump", pcv, 16'h1234);
  endtask

  task automatic t_reject();
    logic [15:0] words [2] = '{16'h8000, 16'h6000};
    for (int i = 0; i < 2; i++) begin
      run(words[i], 16'h0000);
      check("reject", {15'h0, got_rej}, 16'h0001);
      check("reject effects", {14'h0, got_wr, got_pcl}, 16'h0000);
    end
  endtask

  // Hold the enable low in the middle of a jump; nothing may move
  task automatic t_freeze();
    instr_word = {5'h00, 1'b0, 2'h0, 8'h33};
    instr_valid = 1'b1;
    @(posedge sys_clk);
    #1 instr_valid = 1'b0;
    ce = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check("frozen done", {14'h0, op_done, pc_load}, 16'h0000);
    check("frozen ea_valid", {15'h0, ea_valid}, 16'h0000);
    ce = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("thawed done", {14'h0, op_done, pc_load}, 16'h0003);
    check("thawed target", pc_value, 16'h0033);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_modes();
    t_link();
    t_move();
    t_modify();
    t_indirect();
    t_reject();
    t_freeze();
    give_verdict();
  end
endmodule // tb_top
